/* rtl/ibpl_pin_logic.sv */
// Purpose: expansion bus address, data, strobe, a20 and boot rom pins
// Assumes: ext_master_own and suspend are synchronous to core_clk
// Notes: every pin output is registered; enables are low while driving
// Behaviour
// (R1) address lines pick one byte in the megabyte named by upper bits
// (R2) memory cycles carry equal address bits 19:17 on both groups
// (R3) i/o cycles use address bits 15:0 only; 19:16 undefined
// (R4) address driven while device owns bus, input under external master
// (R5) high byte enable marks upper-byte transfer; negated in refresh
// (R6) high byte enable driven when owning, sampled under external master
// (R7) sixteen-bit data bus, high and low byte; undefined in refresh
// (R8) low-megabyte read strobe: delayed memory read below one megabyte
// (R9) low-megabyte write strobe: delayed memory write below one megabyte
// (R10) slave raises no-wait only after decoding address and command
// (R11) no-wait shortens sixteen-bit memory cycles to two bus clocks
// (R12) no-wait shortens eight-bit memory or i/o cycles to three clocks
// (R13) no-wait ignored on sixteen-bit i/o cycles
// (R14) channel ready low with no-wait: no-wait ignored, waits added
// (R15) a20 gate input combined with quick a20 bit onto mask output
// (R16) boot rom select decoded from address and upper address bits
// (R17) boot rom select never asserted in dma cycles
// (R18) boot rom select high in reset, after reset, and suspend
// (R19) address floats in reset, holds last value in suspend
// (R20) data floats in reset and in suspend
// (R21) device asserts memory read as master, dma included
// (R22) device drives refresh indicator during its refresh cycles
// (R23) mask asserted only when gate and quick bit are both low
`timescale 1ns/1ps
module ibpl_pin_logic
  import ibpl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic suspend,
  input wire logic ext_master_own,
  input wire ibpl_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic cyc_done,
  output logic [15:0] rdata,
  input wire ibpl_addr_t addr_in,
  output ibpl_addr_t addr_out,
  output logic addr_oe_b,
  input wire logic [15:0] system_data_bus_in,
  output logic [15:0] system_data_bus_out,
  output logic system_data_bus_oe_b,
  input wire logic mem_read_command_b_in,
  input wire logic mem_write_command_b_in,
  output logic mem_read_command_b_out,
  output logic mem_write_command_b_out,
  output logic mem_command_oe_b,
  output logic io_read_command_b,
  output logic io_write_command_b,
  output logic refresh_b,
  output logic low_mem_read_strobe_b,
  output logic low_mem_write_strobe_b,
  input wire logic no_wait_request_b,
  input wire logic channel_ready,
  input wire logic addr20_gate_in,
  input wire logic [7:0] port92_value,
  output logic addr20_mask_out_b,
  input wire logic [IBPL_ROM_RANGES-1:0] rom_range_en,
  output logic boot_rom_select_b
);

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DONE} ibpl_state_t;

  ibpl_state_t state_reg;
  ibpl_state_t state_next;
  ibpl_req_t cur_reg;
  logic take;
  logic last;
  logic allow_fast;
  logic [3:0] len_norm;
  logic [3:0] len_fast;
  logic own;
  logic bus_rd;
  logic bus_wr;
  logic [23:0] bus_addr;
  logic low_mb;
  logic rom_hit;
  logic [7:0] rom_blk;

  assign own = ~ext_master_own;
  assign take = req_valid & req_ready & own & ~suspend;

  // cycle sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_next = ST_CMD;
      end
      ST_CMD: begin
        if (last) begin
          state_next = ST_DONE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // request latch and handshake
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg <= '0;
      req_ready <= 1'b0;
    end else begin
      if (take) begin
        cur_reg <= req;
      end
      req_ready <= (state_next == ST_IDLE) & ~take;
    end
  end

  // lengths per cycle type
  always_comb begin
    if (cur_reg.is_mem && cur_reg.wide) begin
      len_norm = IBPL_LEN_MEM16_NORM;
      len_fast = IBPL_LEN_MEM16_FAST; // R11
    end else if (cur_reg.wide) begin
      len_norm = IBPL_LEN_IO16_NORM;
      len_fast = IBPL_LEN_IO16_NORM;
    end else begin
      len_norm = IBPL_LEN_8BIT_NORM;
      len_fast = IBPL_LEN_8BIT_FAST; // R12
    end
  end
  // sixteen-bit i/o and refresh never shorten
  assign allow_fast = ~(cur_reg.wide & ~cur_reg.is_mem) & ~cur_reg.refresh; // R13

  ibpl_cycle_timer u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(state_reg == ST_ADDR),
    .run(state_reg == ST_CMD),
    .channel_ready(channel_ready),
    .no_wait_request_b(no_wait_request_b),
    .allow_fast(allow_fast),
    .len_norm(len_norm),
    .len_fast(len_fast),
    .last(last)
  );

  // address group: driven while owning, sa and la held in suspend with hbe_b negated, floats in reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_out <= '{sa: IBPL_SA_RST, la: IBPL_LA_RST, hbe_b: 1'b1};
      addr_oe_b <= 1'b1; // R19
    end else if (suspend) begin
      addr_out.hbe_b <= 1'b1;
      addr_oe_b <= 1'b0; // R19
    end else if (ext_master_own) begin
      addr_oe_b <= 1'b1; // R4 R6
    end else if (take) begin
      addr_out.la <= req.addr[23:17]; // R1
      addr_out.sa <= req.is_mem ? req.addr[19:0] : {4'h0, req.addr[15:0]}; // R2 R3
      addr_out.hbe_b <= ~(req.high_byte & ~req.refresh); // R5
      addr_oe_b <= 1'b0; // R4 R6
    end
  end

  // data: driven only for own writes outside refresh
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      system_data_bus_out <= IBPL_SD_RST;
      system_data_bus_oe_b <= 1'b1; // R20
    end else if (suspend || ext_master_own) begin
      system_data_bus_oe_b <= 1'b1; // R20
    end else if (take) begin
      system_data_bus_out <= req.wdata; // R7
      system_data_bus_oe_b <= ~(req.is_write & ~req.refresh); // R7
    end else if (state_reg == ST_DONE) begin
      system_data_bus_oe_b <= 1'b1;
    end
  end

  // read data capture and completion pulse
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= IBPL_SD_RST;
      cyc_done <= 1'b0;
    end else begin
      cyc_done <= last;
      if (last && !cur_reg.is_write) begin
        rdata <= system_data_bus_in;
      end
    end
  end

  // commands and refresh indicator, active during command clocks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_read_command_b_out <= 1'b1;
      mem_write_command_b_out <= 1'b1;
      mem_command_oe_b <= 1'b1;
      io_read_command_b <= 1'b1;
      io_write_command_b <= 1'b1;
      refresh_b <= 1'b1;
    end else begin
      mem_command_oe_b <= ext_master_own;
      if (state_next == ST_CMD) begin
        mem_read_command_b_out <= ~(cur_reg.is_mem & ~cur_reg.is_write); // R21
        mem_write_command_b_out <= ~(cur_reg.is_mem & cur_reg.is_write);
        io_read_command_b <= ~(~cur_reg.is_mem & ~cur_reg.is_write);
        io_write_command_b <= ~(~cur_reg.is_mem & cur_reg.is_write);
        refresh_b <= ~cur_reg.refresh; // R22
      end else begin
        mem_read_command_b_out <= 1'b1;
        mem_write_command_b_out <= 1'b1;
        io_read_command_b <= 1'b1;
        io_write_command_b <= 1'b1;
        refresh_b <= 1'b1;
      end
    end
  end

  // live command and address on the bus from whichever master owns it
  assign bus_rd = own ? ~mem_read_command_b_out : ~mem_read_command_b_in;
  assign bus_wr = own ? ~mem_write_command_b_out : ~mem_write_command_b_in;
  assign bus_addr = own ? {addr_out.la, addr_out.sa[16:0]} : {addr_in.la, addr_in.sa[16:0]};
  assign low_mb = (bus_addr[23:20] == IBPL_LOW_MB_NIBBLE);

  // low-megabyte strobes follow the command one clock later
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_mem_read_strobe_b <= 1'b1;
      low_mem_write_strobe_b <= 1'b1;
    end else if (suspend) begin
      low_mem_read_strobe_b <= 1'b1;
      low_mem_write_strobe_b <= 1'b1;
    end else begin
      low_mem_read_strobe_b <= ~(bus_rd & low_mb & refresh_b); // R8
      low_mem_write_strobe_b <= ~(bus_wr & low_mb); // R9
    end
  end

  // mask output: low only when gate and quick bit are both low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr20_mask_out_b <= 1'b1;
    end else begin
      addr20_mask_out_b <= addr20_gate_in | port92_value[IBPL_QA20_BIT]; // R15 R23
    end
  end

  // boot rom window decode
  assign rom_blk = bus_addr[23:16];
  assign rom_hit = (rom_range_en[0] && rom_blk == IBPL_ROM_BLK0) ||
                   (rom_range_en[1] && rom_blk == IBPL_ROM_BLK1) ||
                   (rom_range_en[2] && rom_blk == IBPL_ROM_BLK2);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_rom_select_b <= 1'b1; // R18
    end else if (suspend) begin
      boot_rom_select_b <= 1'b1; // R18
    end else begin
      boot_rom_select_b <= ~(rom_hit & (bus_rd | bus_wr) & ~(own & cur_reg.dma)); // R16 R17
    end
  end

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_MEM_ADDR_MATCH: assert property ( // R2
    (state_reg == ST_CMD && cur_reg.is_mem) |-> addr_out.sa[19:17] == addr_out.la[2:0])
    else $error("address bits 19:17 differ between groups");
  AST_HBE_REFRESH: assert property ( // R5
    (state_reg == ST_CMD && cur_reg.refresh) |-> addr_out.hbe_b)
    else $error("high byte enable asserted in refresh");
  AST_ADDR_RELEASE: assert property ( // R4
    (ext_master_own && !suspend) |=> addr_oe_b)
    else $error("address driven under external master");
  AST_LOW_RD: assert property ( // R8
    (own && !suspend && !mem_read_command_b_out && low_mb && refresh_b)
      |=> !low_mem_read_strobe_b)
    else $error("low read strobe missing");
  AST_LOW_WR_HIGH: assert property ( // R9
    (!low_mb && !suspend) |=> low_mem_write_strobe_b)
    else $error("low write strobe above one megabyte");
  AST_FAST16: assert property ( // R11
    (state_reg == ST_ADDR && cur_reg.is_mem && cur_reg.wide && !cur_reg.refresh)
      ##1 (!no_wait_request_b && channel_ready) |-> last)
    else $error("sixteen-bit memory cycle not shortened");
  AST_FAST8: assert property ( // R12
    (state_reg == ST_ADDR && !cur_reg.wide && !cur_reg.refresh)
      ##1 (!no_wait_request_b && channel_ready)[*2] |-> last)
    else $error("eight-bit cycle not shortened");
  AST_IO16_NORMAL: assert property ( // R13
    (state_reg == ST_ADDR && !cur_reg.is_mem && cur_reg.wide) ##1 channel_ready |-> !last)
    else $error("sixteen-bit i/o cycle shortened");
  AST_WAIT: assert property ( // R14
    (state_reg == ST_CMD && !channel_ready) |-> !last)
    else $error("cycle ended while channel ready low");
  AST_A20: assert property ( // R23
    (!addr20_gate_in && !port92_value[IBPL_QA20_BIT]) |=> !addr20_mask_out_b)
    else $error("mask not asserted");
  AST_ROM_DMA: assert property ( // R17
    (own && $past(cur_reg.dma) && $past(state_reg) != ST_IDLE) |-> boot_rom_select_b)
    else $error("boot rom select in dma cycle");
  AST_ROM_SUSP: assert property ( // R18
    $past(suspend) |-> boot_rom_select_b)
    else $error("boot rom select in suspend");

  COV_MEM16_FAST: cover property (state_reg == ST_ADDR && cur_reg.is_mem && cur_reg.wide
    ##1 last);
  COV_WAIT: cover property (state_reg == ST_CMD && !channel_ready ##1 last);
  COV_EXT_LOW_RD: cover property (ext_master_own && !mem_read_command_b_in ##1
    !low_mem_read_strobe_b);

endmodule

/* rtl/ibpl_pkg.sv */
// Purpose: shared types and constants of the expansion bus pin logic
// Assumes: one bus clock per core_clk edge
// Notes: cycle lengths count whole bus clocks, address clock included
package ibpl_pkg;

  // normal cycle lengths in bus clocks
  localparam logic [3:0] IBPL_LEN_MEM16_NORM = 4'h3;
  localparam logic [3:0] IBPL_LEN_IO16_NORM = 4'h3;
  localparam logic [3:0] IBPL_LEN_8BIT_NORM = 4'h6;
  // shortened lengths under a no-wait request
  localparam logic [3:0] IBPL_LEN_MEM16_FAST = 4'h2;
  localparam logic [3:0] IBPL_LEN_8BIT_FAST = 4'h3;
  localparam logic [3:0] IBPL_CNT_ONE = 4'h1;

  // low megabyte: upper address nibble zero (0x000000 to 0x0FFFFF)
  localparam logic [3:0] IBPL_LOW_MB_NIBBLE = 4'h0;

  // boot rom windows, each a 64 KiB block named by address bits 23:16
  localparam logic [7:0] IBPL_ROM_BLK0 = 8'h0F;
  localparam logic [7:0] IBPL_ROM_BLK1 = 8'h0E;
  localparam logic [7:0] IBPL_ROM_BLK2 = 8'hFF;
  localparam int IBPL_ROM_RANGES = 3;

  // quick address-20 bit position in the port 92 value
  localparam int IBPL_QA20_BIT = 1;

  // reset values of pins
  localparam logic [19:0] IBPL_SA_RST = 20'h00000;
  localparam logic [15:0] IBPL_SD_RST = 16'h0000;
  localparam logic [6:0] IBPL_LA_RST = 7'h00;

  // internal cycle request
  typedef struct packed {
    logic is_mem;
    logic is_write;
    logic wide;
    logic dma;
    logic refresh;
    logic high_byte;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ibpl_req_t;

  // address bus group: low address sa, upper address la, high byte enable (low active)
  typedef struct packed {
    logic [19:0] sa;
    logic [6:0] la;
    logic hbe_b;
  } ibpl_addr_t;

endpackage

/* rtl/ibpl_cycle_timer.sv */
// Purpose: counts bus clocks of one cycle and marks its last clock
// Assumes: start in the address clock, run in the command clocks
// Notes: a no-wait request counts only when channel ready is high
`timescale 1ns/1ps
module ibpl_cycle_timer
  import ibpl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic run,
  input wire logic channel_ready,
  input wire logic no_wait_request_b,
  input wire logic allow_fast,
  input wire logic [3:0] len_norm,
  input wire logic [3:0] len_fast,
  output logic last
);

  logic [3:0] cnt_reg;
  logic fast_reg;
  logic fast_now;
  logic [3:0] cnt_inc;

  // a no-wait request beside a low channel ready is ignored
  assign fast_now = allow_fast & ~no_wait_request_b & channel_ready; // R14
  assign cnt_inc = cnt_reg + IBPL_CNT_ONE;
  // channel ready low always adds a wait state
  assign last = run & channel_ready &
                (cnt_inc >= ((fast_reg | fast_now) ? len_fast : len_norm));

  // clock counter of the cycle; a wait state does not count toward the length
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 4'h0;
    end else if (start) begin
      cnt_reg <= IBPL_CNT_ONE;
    end else if (run && channel_ready && cnt_reg != 4'hF) begin // R14
      cnt_reg <= cnt_inc;
    end
  end

  // remembers a granted shortening for the rest of the cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_reg <= 1'b0;
    end else if (start) begin
      fast_reg <= 1'b0;
    end else if (fast_now && run) begin
      fast_reg <= 1'b1;
    end
  end

endmodule

/* verification/ibpl_slave_model.sv */
// Purpose: expansion bus slave seen from the pin logic
// Assumes: commands are the device's own active-low outputs
// Notes: a released data bus shows the inverse of its last value
`timescale 1ns/1ps
module ibpl_slave_model #(
  parameter logic [15:0] READ_VAL = 16'hA5C3
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic rd_b,
  input wire logic cmd_b,
  input wire logic refresh_b,
  input wire logic [1:0] nw_mode,
  input wire logic [3:0] wait_n,
  input wire logic [15:0] dev_out,
  input wire logic dev_oe_b,
  output logic [15:0] sd_wire,
  output logic no_wait_request_b,
  output logic channel_ready
);
  logic [3:0] cnt_reg;
  logic [15:0] last_reg;
  // command clock counter and last bus value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 4'h0;
      last_reg <= 16'h0000;
    end else begin
      cnt_reg <= cmd_b ? 4'h0 : cnt_reg + 4'h1;
      last_reg <= sd_wire;
    end
  end
  // ready held low for the first wait_n command clocks
  assign channel_ready = cmd_b | (cnt_reg >= wait_n);
  // no-wait only inside a decoded command; mode 2 only while not ready
  assign no_wait_request_b = cmd_b ? 1'b1 : (nw_mode == 2'h1) ? 1'b0 :
    (nw_mode == 2'h2) ? channel_ready : 1'b1;
  // slave drives read data, never in refresh
  assign sd_wire = !dev_oe_b ? dev_out : (!rd_b && refresh_b) ? READ_VAL : ~last_reg;
endmodule

/* verification/isa_bus_pin_logic_bench.sv */
// Purpose: self-checking bench of the expansion bus pin logic
// Assumes: inputs change on the falling edge of core_clk
// Notes: cycle length is counted from the take edge to cyc_done
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (b)); end end
module isa_bus_pin_logic_bench;
  import ibpl_pkg::*;
  logic core_clk = 0, rst_b = 0, suspend = 0, ext_master_own = 0, req_valid = 0;
  logic req_ready, cyc_done, addr_oe_b, sd_oe_b, rd_out_b, wr_out_b, cmd_oe_b;
  logic io_rd_b, io_wr_b, refresh_b, lr_b, lw_b, nw_b, chrdy, mask_b, rom_b;
  logic gate = 0, ext_rd_b = 1, ext_wr_b = 1, in_cyc = 0;
  logic s_lr, s_lw, s_rom, s_hbe, s_ref;
  logic [7:0] p92 = 8'h00;
  logic [2:0] rom_en = 3'h0;
  logic [1:0] nw_mode = 2'h0;
  logic [3:0] wait_n = 4'h0;
  logic [15:0] rdata, sd_out, sd_wire, cap_sd;
  ibpl_req_t req = '0;
  ibpl_addr_t addr_out, ext_addr = '0, addr_in, cap_a;
  int error_cnt = 0, checked = 0, n_len;
  assign addr_in = !addr_oe_b ? addr_out : ext_addr;
  ibpl_pin_logic uut (.core_clk(core_clk), .rst_b(rst_b), .suspend(suspend),
    .ext_master_own(ext_master_own), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .cyc_done(cyc_done), .rdata(rdata), .addr_in(addr_in),
    .addr_out(addr_out), .addr_oe_b(addr_oe_b), .system_data_bus_in(sd_wire),
    .system_data_bus_out(sd_out), .system_data_bus_oe_b(sd_oe_b),
    .mem_read_command_b_in(!cmd_oe_b ? rd_out_b : ext_rd_b),
    .mem_write_command_b_in(!cmd_oe_b ? wr_out_b : ext_wr_b),
    .mem_read_command_b_out(rd_out_b), .mem_write_command_b_out(wr_out_b),
    .mem_command_oe_b(cmd_oe_b), .io_read_command_b(io_rd_b),
    .io_write_command_b(io_wr_b), .refresh_b(refresh_b), .low_mem_read_strobe_b(lr_b),
    .low_mem_write_strobe_b(lw_b), .no_wait_request_b(nw_b), .channel_ready(chrdy),
    .addr20_gate_in(gate), .port92_value(p92), .addr20_mask_out_b(mask_b),
    .rom_range_en(rom_en), .boot_rom_select_b(rom_b));
  ibpl_slave_model slave (.core_clk(core_clk), .rst_b(rst_b), .rd_b(rd_out_b & io_rd_b),
    .cmd_b(rd_out_b & io_rd_b & wr_out_b & io_wr_b), .refresh_b(refresh_b),
    .nw_mode(nw_mode), .wait_n(wait_n), .dev_out(sd_out), .dev_oe_b(sd_oe_b),
    .sd_wire(sd_wire), .no_wait_request_b(nw_b), .channel_ready(chrdy));
  // clock of 100 ns
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // records what the pins showed during a cycle
  always @(negedge core_clk) begin
    if (in_cyc) begin
      if (lr_b === 1'b0) s_lr = 1;
      if (lw_b === 1'b0) s_lw = 1;
      if (rom_b === 1'b0) s_rom = 1;
      if (refresh_b === 1'b0) s_ref = 1;
      if (addr_out.hbe_b === 1'b0 && addr_oe_b === 1'b0) s_hbe = 1;
      if ((rd_out_b & wr_out_b & io_rd_b & io_wr_b) === 1'b0) cap_a = addr_out;
      if (sd_oe_b === 1'b0) cap_sd = sd_out;
    end
  end
  function automatic ibpl_req_t mk(input logic m, w, wd, d, rf, hb, input logic [23:0] a);
    mk = '{m, w, wd, d, rf, hb, a, 16'h3C5A};
  endfunction
  // runs one internal cycle and counts its length
  task automatic cyc(input ibpl_req_t r);
    {s_lr, s_lw, s_rom, s_hbe, s_ref} = '0;
    in_cyc = 1;
    n_len = 0;
    while (req_ready !== 1'b1 && n_len < 50) begin
      @(negedge core_clk);
      n_len++;
    end
    req = r;
    req_valid = 1;
    @(negedge core_clk);
    req_valid = 0;
    n_len = 1;
    while (cyc_done !== 1'b1 && n_len < 40) begin
      @(negedge core_clk);
      n_len++;
    end
    `CHK(cyc_done, 1'b1)
    repeat (2) @(negedge core_clk);
    in_cyc = 0;
  endtask
  task automatic t_mem16();
    nw_mode = 2'h1;
    cyc(mk(1, 0, 1, 0, 0, 1, 24'h0A2346));
    `CHK(n_len, 3)
    `CHK(rdata, 16'hA5C3)
    `CHK(cap_a.sa, 20'hA2346)
    `CHK(cap_a.la, 7'h05)
    `CHK(s_lr, 1'b1)
    `CHK(s_hbe, 1'b1)
    nw_mode = 2'h0;
    cyc(mk(1, 0, 1, 0, 0, 1, 24'h0A2346));
    `CHK(n_len, 4)
  endtask
  task automatic t_short();
    nw_mode = 2'h1;
    cyc(mk(1, 0, 0, 0, 0, 0, 24'h001000));
    `CHK(n_len, 4)
    cyc(mk(0, 0, 0, 0, 0, 0, 24'h000060));
    `CHK(n_len, 4)
    `CHK(rdata, 16'hA5C3)
    cyc(mk(0, 0, 1, 0, 0, 0, 24'h0F0378));
    `CHK(n_len, 4)
    `CHK(cap_a.sa[19:16], 4'h0)
    nw_mode = 2'h0;
    cyc(mk(0, 0, 0, 0, 0, 0, 24'h000060));
    `CHK(n_len, 7)
  endtask
  task automatic t_ready();
    nw_mode = 2'h2;
    wait_n = 4'h2;
    cyc(mk(1, 1, 1, 0, 0, 1, 24'h004000));
    `CHK(n_len, 6)
    `CHK(s_lw, 1'b1)
    `CHK(cap_sd, 16'h3C5A)
    wait_n = 4'h0;
    nw_mode = 2'h0;
  endtask
  task automatic t_rom();
    rom_en = 3'h1;
    cyc(mk(1, 0, 1, 0, 0, 0, 24'h0F1000));
    `CHK(s_rom, 1'b1)
    cyc(mk(1, 0, 1, 1, 0, 0, 24'h0F1000));
    `CHK(s_rom, 1'b0)
    rom_en = 3'h4;
    cyc(mk(1, 0, 1, 0, 0, 0, 24'h0F1000));
    `CHK(s_rom, 1'b0)
    cyc(mk(1, 0, 1, 0, 0, 0, 24'hFF0010));
    `CHK(s_rom, 1'b1)
    `CHK(s_lr, 1'b0)
    cyc(mk(1, 0, 1, 0, 1, 1, 24'h000010));
    `CHK(s_ref, 1'b1)
    `CHK(s_hbe, 1'b0)
  endtask
  task automatic t_mask();
    for (int i = 0; i < 4; i++) begin
      gate = i[0];
      p92 = {6'h00, i[1], 1'b0};
      repeat (2) @(negedge core_clk);
      `CHK(mask_b, gate | p92[IBPL_QA20_BIT])
    end
  endtask
  task automatic t_ext();
    ext_master_own = 1;
    req_valid = 1;
    req = mk(1, 0, 1, 0, 0, 0, 24'h001000);
    ext_addr = '{20'h12345, 7'h00, 1'b1};
    repeat (3) @(negedge core_clk);
    `CHK(addr_oe_b, 1'b1)
    `CHK(cmd_oe_b, 1'b1)
    ext_rd_b = 0;
    repeat (2) @(negedge core_clk);
    `CHK(lr_b, 1'b0)
    ext_rd_b = 1;
    ext_addr.la = 7'h08;
    @(negedge core_clk);
    ext_wr_b = 0;
    repeat (2) @(negedge core_clk);
    `CHK(lw_b, 1'b1)
    `CHK(cyc_done, 1'b0)
    ext_wr_b = 1;
    req_valid = 0;
    ext_master_own = 0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic t_susp();
    cyc(mk(1, 0, 1, 0, 0, 0, 24'h0F1000));
    suspend = 1;
    repeat (3) @(negedge core_clk);
    `CHK(addr_oe_b, 1'b0)
    `CHK(addr_out.sa, 20'hF1000)
    `CHK(sd_oe_b, 1'b1)
    `CHK(rom_b, 1'b1)
    suspend = 0;
  endtask
  task automatic report_and_stop();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #(3000 * 100);
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (5) @(negedge core_clk);
    `CHK(rom_b, 1'b1)
    `CHK(addr_oe_b, 1'b1)
    `CHK(sd_oe_b, 1'b1)
    repeat (5) @(negedge core_clk);
    rst_b = 1;
    repeat (2) @(negedge core_clk);
    `CHK(rom_b, 1'b1)
    t_mem16();
    t_short();
    t_ready();
    t_rom();
    t_mask();
    t_ext();
    t_susp();
    report_and_stop();
  end
endmodule
